// File: hdl/mpm_cfg.svh
// Offsets, field positions, reset values and limits of the mode manager.
// Assumes inclusion by bare name from the hdl folder.
`ifndef MPM_CFG_SVH
`define MPM_CFG_SVH
`define MPM_OFF_CTRL 8'h00
`define MPM_OFF_CMD 8'h04
`define MPM_OFF_HOST_SPEED 8'h08
`define MPM_OFF_STATUS 8'h0c
`define MPM_OFF_IRQ_STAT 8'h10
`define MPM_OFF_IRQ_CLR 8'h14
`define MPM_OFF_IRQ_EN 8'h18
`define MPM_OFF_SPEED_CMD 8'h1c
`define MPM_CMD_STOP_BIT 0
`define MPM_CMD_RUN_BIT 1
`define MPM_CMD_RESET_BIT 2
`define MPM_CTRL_RST 1'h0
`define MPM_HOST_SPEED_RST 16'h0000
`define MPM_IRQ_EN_RST 5'h00
`define MPM_UI_SEL_HOST_LINK 1'h0
`define MPM_UI_SEL_BOARD 1'h1
`define MPM_UI_SOURCE_COUNT 2
`define MPM_SWITCH_ON_LEVEL 1'h0
`define MPM_SWITCH_OFF_LEVEL 1'h1
`define MPM_DEBOUNCE_CNT 10
`define MPM_FLT_OC_SW 0
`define MPM_FLT_OV 1
`define MPM_FLT_UV 2
`define MPM_FLT_SPEED 3
`define MPM_FLT_OC_HW 4
`define MPM_FLT_COUNT 5
`define MPM_OC_LIMIT_MA 890
`define MPM_OV_LIMIT_MV 28000
`define MPM_UV_LIMIT_MV 14000
`define MPM_SPEED_LIMIT_RPM 3000
`define MPM_MAX_SPEED_RPM 2650
`define MPM_POT_SPEED_MARGIN 50
`define MPM_POT_SCALE_SHIFT 11
`define MPM_PREP_CYCLES 16
`endif

// File: hdl/mpm_pkg.sv
// Types shared by the mode manager modules.
// Assumes nothing beyond a SystemVerilog compiler.
package mpm_pkg;
	typedef enum logic [1:0] {mode_stopped, mode_running, mode_error} mpm_mode_t;
	typedef enum logic [1:0] {run_init, run_prep, run_drive} mpm_run_t;
	typedef logic signed [15:0] mpm_sample_t;
endpackage

// File: hdl/mpm_fault_if.sv
// Carries fault detections from the checker to the mode manager.
// Assumes both ends run on pclk.
`timescale 1ns/1ns
`include "mpm_cfg.svh"
interface mpm_fault_if;
	logic [`MPM_FLT_COUNT-1:0] hit;
	modport chk (output hit);
	modport mgr (input hit);
endinterface

// File: hdl/mpm_debounce.sv
// Per-switch debounce: a change is taken after CNT equal differing samples.
// Assumes raw switch levels synchronous to pclk, 0 meaning on.
`timescale 1ns/1ns
`include "mpm_cfg.svh"
module mpm_debounce #(
	parameter int N = 2,
	parameter int CNT = `MPM_DEBOUNCE_CNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [N-1:0] raw,
	output logic [N-1:0] stable_q
);
	import mpm_pkg::*;
	localparam int CW = $clog2(CNT + 1);
	localparam logic [CW-1:0] LAST = CW'(CNT - 1);
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_sw
			logic [CW-1:0] cnt_q;
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cnt_q <= '0;
					stable_q[i] <= `MPM_SWITCH_OFF_LEVEL;
				end
				else if (raw[i] == stable_q[i])
					cnt_q <= '0;
				else if (cnt_q == LAST)
				begin
					cnt_q <= '0;
					stable_q[i] <= raw[i]; // R9
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
		end
	endgenerate
endmodule

// File: hdl/mpm_fault_check.sv
// Protection comparators sampled once per current control interval tick.
// Assumes currents in mA, bus voltage in mV, speed in rpm, all signed.
`timescale 1ns/1ns
`include "mpm_cfg.svh"
module mpm_fault_check #(
	parameter int OC_LIMIT = `MPM_OC_LIMIT_MA,
	parameter int OV_LIMIT = `MPM_OV_LIMIT_MV,
	parameter int UV_LIMIT = `MPM_UV_LIMIT_MV,
	parameter int SPEED_LIMIT = `MPM_SPEED_LIMIT_RPM
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ctrl_tick,
	input mpm_pkg::mpm_sample_t cur_u,
	input mpm_pkg::mpm_sample_t cur_v,
	input mpm_pkg::mpm_sample_t cur_w,
	input mpm_pkg::mpm_sample_t vbus_mv,
	input mpm_pkg::mpm_sample_t speed_rpm,
	input wire logic oc_estop,
	mpm_fault_if.chk flt
);
	import mpm_pkg::*;
	localparam logic [16:0] OC_L = 17'(OC_LIMIT);
	localparam logic [16:0] SP_L = 17'(SPEED_LIMIT);
	localparam logic signed [16:0] OV_L = 17'(OV_LIMIT);
	localparam logic signed [16:0] UV_L = 17'(UV_LIMIT);
	logic [`MPM_FLT_COUNT-1:0] hit_q;

	// Widened by one bit so the most negative sample has a magnitude
	function automatic logic [16:0] mag(input mpm_sample_t v);
		logic signed [16:0] e;
		e = {v[15], v};
		mag = (e < 0) ? 17'(-e) : 17'(e);
	endfunction

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hit_q <= '0;
		else
		begin
			hit_q[`MPM_FLT_OC_SW] <= ctrl_tick & ((mag(cur_u) > OC_L) |
				(mag(cur_v) > OC_L) | (mag(cur_w) > OC_L)); // R5
			hit_q[`MPM_FLT_OV] <= ctrl_tick &
				($signed({vbus_mv[15], vbus_mv}) > OV_L); // R6
			hit_q[`MPM_FLT_UV] <= ctrl_tick &
				($signed({vbus_mv[15], vbus_mv}) < UV_L); // R7
			hit_q[`MPM_FLT_SPEED] <= ctrl_tick & (mag(speed_rpm) > SP_L); // R8
			hit_q[`MPM_FLT_OC_HW] <= oc_estop;
		end
	end
	assign flt.hit = hit_q;
endmodule

// File: hdl/mpm_top.sv
// System mode manager and protection logic for a 120-degree motor drive,
// with an APB register slave, board switch and potentiometer handling.
// Assumes all inputs synchronous to pclk; ctrl_tick is a one-cycle pulse
// per current control interval; oc_estop is an active-high level.
`timescale 1ns/1ns
`include "mpm_cfg.svh"

// Summary of operation
// R1 - Exactly one of three modes: stopped, running or error.
// R2 - Stop, run and reset come from users; error only from fault detection.
// R3 - Run sequencing starts on entering running and advances only while running.
// R4 - Hardware overcurrent stop floats every PWM pin at once, no software.
// R5 - Each control tick, any phase current above 0.89 A forces error stop.
// R6 - Each control tick, bus voltage above 28 V forces error stop.
// R7 - Each control tick, bus voltage below 14 V forces error stop.
// R8 - Each control tick, speed above 3000 rpm forces error stop.
// R9 - Switches change after 10 consistent samples; 0 is on, 1 is off.
// R10 - Selector 0 picks host link, 1 picks board controls, two sources.
// R11 - Pot speed is reading times (max speed plus 50 rpm) over 2048.
// R12 - Error holds motor stopped, ignores run, leaves only on user reset.
module mpm_top #(
	parameter int MAX_SPEED = `MPM_MAX_SPEED_RPM,
	parameter int PREP_CYCLES = `MPM_PREP_CYCLES,
	parameter int DEBOUNCE = `MPM_DEBOUNCE_CNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic ctrl_tick,
	input mpm_pkg::mpm_sample_t cur_u,
	input mpm_pkg::mpm_sample_t cur_v,
	input mpm_pkg::mpm_sample_t cur_w,
	input mpm_pkg::mpm_sample_t vbus_mv,
	input mpm_pkg::mpm_sample_t speed_rpm,
	input wire logic oc_estop,
	input wire logic sw_run_n,
	input wire logic sw_reset_n,
	input wire logic [11:0] speed_potentiometer,
	input wire logic [5:0] pwm_in,
	output logic [5:0] pwm_out,
	output logic [5:0] pwm_oe,
	output mpm_pkg::mpm_mode_t mode,
	output mpm_pkg::mpm_run_t run_mode,
	output logic motor_run,
	output logic [15:0] speed_cmd,
	output logic irq
);
	import mpm_pkg::*;

	localparam int PW = $clog2(PREP_CYCLES + 1);
	localparam logic [PW-1:0] PREP_LAST = PW'(PREP_CYCLES - 1);
	localparam logic [12:0] POT_GAIN =
		13'(MAX_SPEED + `MPM_POT_SPEED_MARGIN);

	logic ui_sel_q;
	logic [15:0] host_speed_q;
	logic [`MPM_FLT_COUNT-1:0] irq_stat_q;
	logic [`MPM_FLT_COUNT-1:0] irq_en_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	mpm_mode_t mode_q;
	mpm_run_t run_q;
	logic [PW-1:0] prep_cnt_q;
	logic [1:0] sw_stable;
	logic [1:0] sw_prev_q;
	logic [15:0] speed_cmd_q;
	logic [5:0] pwm_out_q;
	logic motor_run_q;

	logic wr_en;
	logic rd_setup;
	logic cmd_wr;
	logic host_stop;
	logic host_run;
	logic host_reset;
	logic board_run;
	logic board_stop;
	logic board_reset;
	logic ev_stop;
	logic ev_run;
	logic ev_reset;
	logic ev_error;
	logic [24:0] pot_prod;
	logic [15:0] pot_speed;
	logic [31:0] rd_mux;
	logic rd_hit;

	mpm_fault_if flt_if();

	mpm_fault_check u_check (
		.pclk(pclk),
		.presetn(presetn),
		.ctrl_tick(ctrl_tick),
		.cur_u(cur_u),
		.cur_v(cur_v),
		.cur_w(cur_w),
		.vbus_mv(vbus_mv),
		.speed_rpm(speed_rpm),
		.oc_estop(oc_estop),
		.flt(flt_if.chk)
	);

	mpm_debounce #(
		.N(2),
		.CNT(DEBOUNCE)
	) u_debounce (
		.pclk(pclk),
		.presetn(presetn),
		.raw({sw_reset_n, sw_run_n}),
		.stable_q(sw_stable)
	);

	// APB: zero wait states; read data is captured in the setup cycle so
	// the access phase presents it straight from a flip-flop.
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign wr_en = psel & penable & pwrite & ~pslverr_q;
	assign rd_setup = psel & ~penable;
	assign cmd_wr = wr_en & (paddr == `MPM_OFF_CMD);

	always_comb
	begin
		rd_mux = '0;
		rd_hit = 1'b1;
		case (paddr)
			`MPM_OFF_CTRL:
				rd_mux = {31'h0, ui_sel_q};
			`MPM_OFF_CMD:
				rd_mux = '0;
			`MPM_OFF_HOST_SPEED:
				rd_mux = {16'h0, host_speed_q};
			`MPM_OFF_STATUS:
				rd_mux = {27'h0, motor_run_q, run_q, mode_q};
			`MPM_OFF_IRQ_STAT:
				rd_mux = {27'h0, irq_stat_q};
			`MPM_OFF_IRQ_CLR:
				rd_mux = '0;
			`MPM_OFF_IRQ_EN:
				rd_mux = {27'h0, irq_en_q};
			`MPM_OFF_SPEED_CMD:
				rd_mux = {16'h0, speed_cmd_q};
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end
		else if (rd_setup)
		begin
			prdata_q <= pwrite ? 32'h0 : rd_mux;
			pslverr_q <= ~rd_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ui_sel_q <= `MPM_CTRL_RST;
			host_speed_q <= `MPM_HOST_SPEED_RST;
			irq_en_q <= `MPM_IRQ_EN_RST;
		end
		else if (wr_en)
		begin
			case (paddr)
				`MPM_OFF_CTRL:
					ui_sel_q <= pwdata[0]; // R10
				`MPM_OFF_HOST_SPEED:
					host_speed_q <= pwdata[15:0];
				`MPM_OFF_IRQ_EN:
					irq_en_q <= pwdata[`MPM_FLT_COUNT-1:0];
				default:
					ui_sel_q <= ui_sel_q;
			endcase
		end
	end

	// Host link events come from command writes, board events from
	// debounced switch edges; only the selected source is heard.
	assign host_stop = cmd_wr & pwdata[`MPM_CMD_STOP_BIT];
	assign host_run = cmd_wr & pwdata[`MPM_CMD_RUN_BIT];
	assign host_reset = cmd_wr & pwdata[`MPM_CMD_RESET_BIT];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sw_prev_q <= {2{`MPM_SWITCH_OFF_LEVEL}};
		else
			sw_prev_q <= sw_stable;
	end

	// Edges rather than levels, so a switch left on after an error reset
	// does not restart the motor by itself.
	assign board_run = (sw_stable[0] == `MPM_SWITCH_ON_LEVEL) &
		(sw_prev_q[0] == `MPM_SWITCH_OFF_LEVEL); // R9
	assign board_stop = (sw_stable[0] == `MPM_SWITCH_OFF_LEVEL) &
		(sw_prev_q[0] == `MPM_SWITCH_ON_LEVEL);
	assign board_reset = (sw_stable[1] == `MPM_SWITCH_ON_LEVEL) &
		(sw_prev_q[1] == `MPM_SWITCH_OFF_LEVEL);

	always_comb
	begin
		if (ui_sel_q == `MPM_UI_SEL_BOARD) // R10
		begin
			ev_stop = board_stop;
			ev_run = board_run;
			ev_reset = board_reset;
		end
		else
		begin
			ev_stop = host_stop;
			ev_run = host_run;
			ev_reset = host_reset;
		end
	end

	assign ev_error = |flt_if.hit; // R2

	// Error outranks every user event in the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= mode_stopped;
		else
		begin
			case (mode_q) // R1
				mode_stopped:
					if (ev_error)
						mode_q <= mode_error; // R5 R6 R7 R8
					else if (ev_run && !ev_stop)
						mode_q <= mode_running; // R2
				mode_running:
					if (ev_error)
						mode_q <= mode_error; // R5 R6 R7 R8
					else if (ev_stop || ev_reset)
						mode_q <= mode_stopped; // R2
				mode_error:
					if (ev_reset && !ev_error)
						mode_q <= mode_stopped; // R12
				default:
					mode_q <= mode_error;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_q <= run_init;
			prep_cnt_q <= '0;
		end
		else if (mode_q != mode_running || ev_error || ev_stop || ev_reset)
		begin
			run_q <= run_init; // R3
			prep_cnt_q <= '0;
		end
		else
		begin
			case (run_q) // R3
				run_init:
				begin
					run_q <= run_prep;
					prep_cnt_q <= '0;
				end
				run_prep:
					if (prep_cnt_q == PREP_LAST)
						run_q <= run_drive;
					else
						prep_cnt_q <= prep_cnt_q + 1'b1;
				run_drive:
					run_q <= run_drive;
				default:
					run_q <= run_init;
			endcase
		end
	end

	// Drive drops in the same edge that a fault is seen, not one later.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			motor_run_q <= 1'b0;
		else
			motor_run_q <= (mode_q == mode_running) && (run_q == run_drive) &&
				!ev_error; // R12
	end

	assign pot_prod = 25'(speed_potentiometer * POT_GAIN);
	assign pot_speed = 16'(pot_prod >> `MPM_POT_SCALE_SHIFT); // R11

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			speed_cmd_q <= '0;
		else if (mode_q != mode_running)
			speed_cmd_q <= '0;
		else if (ui_sel_q == `MPM_UI_SEL_BOARD)
			speed_cmd_q <= pot_speed; // R11
		else
			speed_cmd_q <= host_speed_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pwm_out_q <= '0;
		else
			pwm_out_q <= motor_run_q ? pwm_in : 6'h00;
	end

	// The overcurrent pin reaches the enables combinationally, so the
	// bridge floats in the same cycle regardless of any register state.
	assign pwm_oe = {6{motor_run_q & ~oc_estop}}; // R4
	assign pwm_out = pwm_out_q;

	// Sticky fault status; a detection in the clearing cycle survives.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat_q <= '0;
		else if (wr_en && paddr == `MPM_OFF_IRQ_CLR)
			irq_stat_q <= (irq_stat_q & ~pwdata[`MPM_FLT_COUNT-1:0]) |
				flt_if.hit;
		else
			irq_stat_q <= irq_stat_q | flt_if.hit;
	end

	assign irq = |(irq_stat_q & irq_en_q);
	assign mode = mode_q;
	assign run_mode = run_q;
	assign motor_run = motor_run_q;
	assign speed_cmd = speed_cmd_q;
endmodule

// File: testbench/mpm_plant.sv
// Stand-in for the inverter, sensors and PWM source of the drive.
// Assumes pclk and presetn of the bench; flt_sel picks a sensor fault.
`timescale 1ns/1ns
module mpm_plant
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] flt_sel,
	output logic ctrl_tick,
	output mpm_pkg::mpm_sample_t cur_u,
	output mpm_pkg::mpm_sample_t cur_v,
	output mpm_pkg::mpm_sample_t cur_w,
	output mpm_pkg::mpm_sample_t vbus_mv,
	output mpm_pkg::mpm_sample_t speed_rpm,
	output logic [5:0] pwm_in
);
	import mpm_pkg::*;
	logic [2:0] cnt_q;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			cnt_q <= 3'h0;
			pwm_in <= 6'h00;
		end
		else
		begin
			cnt_q <= cnt_q + 3'h1;
			pwm_in <= pwm_in + 6'h05;
		end
	// One control interval every eight clocks keeps fault waits short
	assign ctrl_tick = (cnt_q == 3'h7);
	assign cur_u = 16'h00c8;
	// Code 5 sits exactly on every upper limit and must not trip
	assign cur_v = flt_sel == 3'h1 ? 16'hfc85 :
		flt_sel == 3'h5 ? 16'hfc86 : 16'hff38;
	assign cur_w = 16'h0000;
	assign vbus_mv = flt_sel == 3'h2 ? 16'h6d61 :
		flt_sel == 3'h3 ? 16'h36af :
		flt_sel == 3'h5 ? 16'h6d60 : 16'h5dc0;
	assign speed_rpm = flt_sel == 3'h4 ? 16'h0bb9 :
		flt_sel == 3'h5 ? 16'hf448 : 16'h05dc;
endmodule

// File: testbench/mpm_top_monitor.sv
// Concurrent checks of modes, trips and PWM gating at the top ports.
// Assumes binding onto mpm_top; all signals in the pclk domain.
`timescale 1ns/1ns
module mpm_top_monitor
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ctrl_tick,
	input mpm_pkg::mpm_sample_t cur_u,
	input mpm_pkg::mpm_sample_t cur_v,
	input mpm_pkg::mpm_sample_t cur_w,
	input mpm_pkg::mpm_sample_t vbus_mv,
	input mpm_pkg::mpm_sample_t speed_rpm,
	input wire logic oc_estop,
	input wire logic [5:0] pwm_in,
	input logic [5:0] pwm_out,
	input logic [5:0] pwm_oe,
	input mpm_pkg::mpm_mode_t mode,
	input mpm_pkg::mpm_run_t run_mode,
	input logic motor_run
);
	import mpm_pkg::*;
	function automatic logic [15:0] mag(mpm_sample_t x);
		return x < 0 ? -x : x;
	endfunction
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	mode_legal_a: assert property (mode inside {mode_stopped,
		mode_running, mode_error}) else $error("illegal mode");
	oe_gate_a: assert property (
		pwm_oe == {6{motor_run & ~oc_estop}}) else $error("pwm_oe wrong");
	oc_trip_a: assert property (ctrl_tick && (mag(cur_u) > 890 ||
		mag(cur_v) > 890 || mag(cur_w) > 890) |-> ##2 mode == mode_error)
		else $error("overcurrent not tripped");
	ov_trip_a: assert property (ctrl_tick && vbus_mv > 28000
		|-> ##2 mode == mode_error) else $error("overvoltage not tripped");
	uv_trip_a: assert property (ctrl_tick && vbus_mv < 14000
		|-> ##2 mode == mode_error) else $error("undervoltage not tripped");
	speed_trip_a: assert property (ctrl_tick && mag(speed_rpm) > 3000
		|-> ##2 mode == mode_error) else $error("overspeed not tripped");
	err_hold_a: assert property (mode == mode_error
		|=> mode != mode_running) else $error("left error to running");
	err_stop_a: assert property (mode == mode_error |-> !motor_run)
		else $error("motor runs in error");
	run_gate_a: assert property ($rose(motor_run) |->
		mode == mode_running && $past(run_mode) == run_drive)
		else $error("motor started outside drive");
	idle_init_a: assert property (mode != mode_running
		|-> run_mode == run_init) else $error("run mode not init");
	prep_start_a: assert property (mode == mode_running &&
		$past(mode) == mode_stopped |=> run_mode == run_prep)
		else $error("sequence did not start");
	pwm_pass_a: assert property (motor_run
		|=> pwm_out == $past(pwm_in)) else $error("pwm not passed");
endmodule
bind mpm_top mpm_top_monitor i_mpm_top_monitor (.pclk, .presetn,
	.ctrl_tick, .cur_u, .cur_v, .cur_w, .vbus_mv, .speed_rpm, .oc_estop,
	.pwm_in, .pwm_out, .pwm_oe, .mode, .run_mode, .motor_run);

// File: testbench/mpm_top_tb.sv
// Self-checking bench: APB host, plant model and board switches.
// Assumes the plant model and the bound port monitor.
`timescale 1ns/1ns
`include "mpm_cfg.svh"
`define CHK(n, x, y) \
	checked++; \
	if ((y) !== (x)) \
	begin \
		$display("[FAIL] %s expected %0h seen %0h", n, x, y); \
		num_errors++; \
	end
module mpm_top_tb;
	import mpm_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic oc_estop = 1'h0;
	logic sw_run_n = 1'h1;
	logic sw_reset_n = 1'h1;
	logic [2:0] flt_sel = 3'h0;
	logic pready, pslverr, ctrl_tick, motor_run, irq;
	logic [31:0] prdata;
	logic [5:0] pwm_in, pwm_out, pwm_oe;
	logic [15:0] speed_cmd;
	mpm_sample_t cur_u, cur_v, cur_w, vbus_mv, speed_rpm;
	mpm_mode_t mode;
	mpm_run_t run_mode;
	int num_errors = 0;
	int checked = 0;
	mpm_plant i_mpm_plant (.pclk, .presetn, .flt_sel, .ctrl_tick,
		.cur_u, .cur_v, .cur_w, .vbus_mv, .speed_rpm, .pwm_in);
	// Short prep keeps each start to a handful of cycles
	mpm_top #(.PREP_CYCLES(2)) i_mpm_top (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .pready, .prdata, .pslverr, .ctrl_tick,
		.cur_u, .cur_v, .cur_w, .vbus_mv, .speed_rpm, .oc_estop, .sw_run_n,
		.sw_reset_n, .speed_potentiometer(12'h7ff), .pwm_in, .pwm_out,
		.pwm_oe, .mode, .run_mode, .motor_run, .speed_cmd, .irq);
	initial
	begin
		forever #10 pclk = ~pclk;
	end
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'h1, d, r, e);
	endtask
	task automatic wait_mode(input mpm_mode_t m);
		for (int n = 0; n < 200 && mode !== m; n++)
			@(negedge pclk);
	endtask
	task automatic wait_drive();
		for (int n = 0; n < 200 && motor_run !== 1'h1; n++)
			@(negedge pclk);
	endtask
	task automatic t_host();
		logic [31:0] r;
		logic e;
		`CHK("reset mode", mode_stopped, mode)
		apb(8'h20, 1'h1, 32'h2, r, e);
		`CHK("stray err", 1'h1, e)
		`CHK("stray mode", mode_stopped, mode)
		apb(`MPM_OFF_CTRL, 1'h0, 32'h0, r, e);
		`CHK("ctrl", 32'h0, r)
		wr(`MPM_OFF_IRQ_EN, 32'h1f);
		wr(`MPM_OFF_HOST_SPEED, 32'h3e8);
		wr(`MPM_OFF_CMD, 32'h2);
		// The command lands at the access edge; sequencing starts one later
		@(negedge pclk);
		`CHK("mode", mode_running, mode)
		`CHK("run mode", run_init, run_mode)
		wait_drive();
		`CHK("drive", run_drive, run_mode)
		`CHK("host speed", 16'h03e8, speed_cmd)
		apb(`MPM_OFF_STATUS, 1'h0, 32'h0, r, e);
		`CHK("status", 32'h19, r)
		apb(`MPM_OFF_SPEED_CMD, 1'h0, 32'h0, r, e);
		`CHK("speed reg", 32'h3e8, r)
		@(posedge pclk);
		oc_estop <= 1'h1;
		@(negedge pclk);
		`CHK("pwm_oe", 6'h00, pwm_oe)
		wait_mode(mode_error);
		`CHK("irq", 1'h1, irq)
		apb(`MPM_OFF_IRQ_STAT, 1'h0, 32'h0, r, e);
		`CHK("irq stat", 32'h10, r)
		@(posedge pclk);
		oc_estop <= 1'h0;
		wr(`MPM_OFF_IRQ_CLR, 32'h1f);
		@(negedge pclk);
		`CHK("irq clear", 1'h0, irq)
		wr(`MPM_OFF_CMD, 32'h2);
		repeat (8) @(negedge pclk);
		`CHK("run in error", mode_error, mode)
		wr(`MPM_OFF_CMD, 32'h4);
		wait_mode(mode_stopped);
		`CHK("reset", mode_stopped, mode)
	endtask
	task automatic t_faults();
		logic [31:0] r;
		logic e;
		for (int k = 1; k <= 5; k++)
		begin
			wr(`MPM_OFF_CMD, 32'h2);
			wait_drive();
			@(posedge pclk);
			flt_sel <= 3'(k);
			repeat (20) @(negedge pclk);
			`CHK("trip", k == 5 ? mode_running : mode_error, mode)
			apb(`MPM_OFF_IRQ_STAT, 1'h0, 32'h0, r, e);
			`CHK("trip stat", k == 5 ? 32'h0 : 32'h1 << (k - 1), r)
			@(posedge pclk);
			flt_sel <= 3'h0;
			wr(`MPM_OFF_IRQ_CLR, 32'h1f);
			wr(`MPM_OFF_CMD, k == 5 ? 32'h1 : 32'h4);
			wait_mode(mode_stopped);
			`CHK("stopped", mode_stopped, mode)
		end
	endtask
	task automatic t_board();
		wr(`MPM_OFF_CTRL, 32'h1);
		@(posedge pclk);
		sw_run_n <= 1'h0;
		// Nine equal samples fall one short of the debounce count
		repeat (9) @(posedge pclk);
		sw_run_n <= 1'h1;
		repeat (20) @(negedge pclk);
		`CHK("glitch", mode_stopped, mode)
		@(posedge pclk);
		sw_run_n <= 1'h0;
		wait_drive();
		`CHK("board run", mode_running, mode)
		`CHK("pot speed", 16'((12'h7ff * (`MPM_MAX_SPEED_RPM +
			`MPM_POT_SPEED_MARGIN)) >> 11), speed_cmd)
		@(posedge pclk);
		flt_sel <= 3'h2;
		wait_mode(mode_error);
		@(posedge pclk);
		flt_sel <= 3'h0;
		sw_run_n <= 1'h1;
		sw_reset_n <= 1'h0;
		repeat (12) @(posedge pclk);
		sw_reset_n <= 1'h1;
		wait_mode(mode_stopped);
		`CHK("board reset", mode_stopped, mode)
	endtask
	task automatic complete_run();
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		complete_run();
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		t_host();
		t_faults();
		t_board();
		complete_run();
	end
endmodule
